// File: wave_timer_map.vh
// Contract
// (RULE_01) Counter clocked by one selected source: div1, div2, div8 or companion underflow.
// (RULE_02) Counter decrements; each underflow reloads primary and secondary values alternately.
// (RULE_03) Counting always begins with the primary period.
// (RULE_04) Waveform pin inverts at every main counter underflow.
// (RULE_05) Phase lasts (prescaler+1) times (period+1) count-source cycles.
// (RULE_06) Run bit 1 counts, 0 stops; counting only while it is 1.
// (RULE_07) Interrupt raised after secondary-period underflow, together with the output change.
// (RULE_08) Prescaler and primary register reads return live counter values.
// (RULE_09) During secondary period the main count still reads through primary register.
// (RULE_10) Writes to period and prescaler registers change reload values only.
// (RULE_11) Primary register write commits both primary and secondary reload values.
// (RULE_12) Committed values shape the waveform from the next primary period.
// (RULE_13) Level select bit picks output level for primary and secondary periods.
// (RULE_14) Switch bit 0 drives the toggling waveform on the pin.
// (RULE_15) Switch bit 1 drives the port latch bit on the pin.
// (RULE_16) Switch bit sampled at start or interrupt; applies from next primary period.
// (RULE_17) Software wanting a general port must use plain timer mode instead.
// (RULE_18) Prescaler decrements per source pulse; main counter per prescaler underflow.
`ifndef WAVE_TIMER_MAP_VH
`define WAVE_TIMER_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_PRESCALER 8'h00
`define OFS_SECONDARY 8'h04
`define OFS_PRIMARY 8'h08
`define OFS_MODE 8'h0C
`define OFS_OUTCTL 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_CLEAR 8'h18
`define OFS_IRQ_ENABLE 8'h1C

// ****************************************
// field positions
// ****************************************
`define MODE_RUN 0
`define MODE_SRC_LO 1
`define MODE_SRC_HI 2
`define OUT_LEVEL 0
`define OUT_SWITCH 1
`define OUT_LATCH 2
`define IRQ_SEC_END 0
`define IRQ_UNDERFLOW 1

// ****************************************
// count source codes and divider
// ****************************************
`define SRC_DIV1 2'h0
`define SRC_DIV2 2'h1
`define SRC_DIV8 2'h2
`define SRC_COMPANION 2'h3
`define DIV8_LAST 3'h7

// ****************************************
// reset values
// ****************************************
`define RST_PERIOD 8'hFF
`define RST_MODE 3'h0
`define RST_OUTCTL 3'h0
`define RST_IRQ 2'h0

`endif

// File: wave_timer.v
`timescale 1ns/1ns
`include "wave_timer_map.vh"

module wave_timer #(
    parameter WIDTH = 8,
    parameter IRQ_BITS = 2
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // companion timer
    input wire companion_underflow,
    // waveform and interrupt
    output reg waveform_out_pin,
    output reg irq
);

// ****************************************
// decode
// ****************************************
function [3:0] reg_index;
    input [7:0] addr;
    begin
        reg_index = {1'b0, addr[4:2]};
        if (addr[7:5] != 3'h0) begin
            reg_index = 4'hF;
        end
    end
endfunction

function [WIDTH-1:0] dec_one;
    input [WIDTH-1:0] value;
    begin
        dec_one = value - {{(WIDTH-1){1'b0}}, 1'b1};
    end
endfunction

// ****************************************
// phase codes
// ****************************************
localparam ST_PRIMARY = 2'b01;
localparam ST_SECONDARY = 2'b10;

// ****************************************
// state
// ****************************************
reg [WIDTH-1:0] prescaler_count_reg;
reg [WIDTH-1:0] prescaler_reload;
reg [WIDTH-1:0] main_count;
reg [WIDTH-1:0] secondary_period_reg;
reg [WIDTH-1:0] primary_commit;
reg [WIDTH-1:0] secondary_commit;
reg [WIDTH-1:0] secondary_active;
reg [2:0] timer_mode_reg;
reg [2:0] output_control_reg;
reg [IRQ_BITS-1:0] irq_status;
reg [IRQ_BITS-1:0] irq_enable;
reg [1:0] phase_state;
reg [1:0] next_phase_state;
reg switch_latched;
reg run_prev;
reg [2:0] div_count;
reg wr_pending;
reg [3:0] wr_index;
reg sec_end_seen;
reg underflow_seen;

wire count_run_bit;
wire [1:0] src_sel;
wire output_level_select_bit;
wire output_switch_bit;
wire port_latch_bit;
wire start;
wire primary_begin;
wire secondary_phase;
wire addr_phase;
wire [3:0] rd_index;
reg src_tick;
wire tick;
wire pre_under;
wire main_under;
wire [IRQ_BITS-1:0] irq_event;
wire [IRQ_BITS-1:0] irq_clear;
wire [IRQ_BITS-1:0] next_irq_status;
reg [31:0] next_hrdata;

assign count_run_bit = timer_mode_reg[`MODE_RUN];
assign src_sel = timer_mode_reg[`MODE_SRC_HI:`MODE_SRC_LO];
assign output_level_select_bit = output_control_reg[`OUT_LEVEL];
assign output_switch_bit = output_control_reg[`OUT_SWITCH];
assign port_latch_bit = output_control_reg[`OUT_LATCH];
assign start = count_run_bit & ~run_prev;
assign secondary_phase = (phase_state == ST_SECONDARY);
assign addr_phase = hsel & htrans[1] & hready;
assign rd_index = reg_index(haddr);

// ****************************************
// count source
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        div_count <= 3'h0;
    end else begin
        div_count <= div_count + 3'h1;
    end
end

// RULE_01 source select
always @* begin
    case (src_sel)
        `SRC_DIV1: src_tick = 1'b1;
        `SRC_DIV2: src_tick = div_count[0];
        `SRC_DIV8: src_tick = (div_count == `DIV8_LAST);
        `SRC_COMPANION: src_tick = companion_underflow;
        default: src_tick = 1'b0;
    endcase
end

// RULE_06 count only while running
assign tick = src_tick & count_run_bit & ~start;
// RULE_18 prescaler then main counter
assign pre_under = tick & (prescaler_count_reg == {WIDTH{1'b0}});
assign main_under = pre_under & (main_count == {WIDTH{1'b0}});
assign primary_begin = start | (main_under & secondary_phase);

// ****************************************
// phase state
// ****************************************
// RULE_04 phase flip drives the toggle
always @* begin
    next_phase_state = phase_state;
    case (phase_state)
        ST_PRIMARY: begin
            if (main_under) begin
                next_phase_state = ST_SECONDARY;
            end
        end
        ST_SECONDARY: begin
            if (main_under) begin
                next_phase_state = ST_PRIMARY;
            end
        end
        default: begin
            next_phase_state = ST_PRIMARY;
        end
    endcase
    // RULE_03 primary period first
    if (start) begin
        next_phase_state = ST_PRIMARY;
    end
end

always @(posedge mclk) begin
    if (reset) begin
        phase_state <= ST_PRIMARY;
    end else begin
        phase_state <= next_phase_state;
    end
end

// ****************************************
// counters
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        run_prev <= 1'b0;
    end else begin
        run_prev <= count_run_bit;
    end
end

// RULE_18 prescaler stage
always @(posedge mclk) begin
    if (reset) begin
        prescaler_count_reg <= `RST_PERIOD;
    end else if (start | pre_under) begin
        // RULE_05 reload each prescaler pass
        prescaler_count_reg <= prescaler_reload;
    end else if (tick) begin
        prescaler_count_reg <= dec_one(prescaler_count_reg);
    end
end

always @(posedge mclk) begin
    if (reset) begin
        main_count <= `RST_PERIOD;
    end else if (start) begin
        main_count <= primary_commit;
    end else if (main_under) begin
        if (secondary_phase) begin
            // RULE_12 new values at next primary period
            main_count <= primary_commit;
        end else begin
            // RULE_02 alternate reload
            main_count <= secondary_active;
        end
    end else if (pre_under) begin
        main_count <= dec_one(main_count);
    end
end

// secondary reload refreshed as each primary period begins
always @(posedge mclk) begin
    if (reset) begin
        secondary_active <= `RST_PERIOD;
    end else if (primary_begin) begin
        secondary_active <= secondary_commit;
    end
end

// RULE_16 switch sampled at start or interrupt
always @(posedge mclk) begin
    if (reset) begin
        switch_latched <= 1'b0;
    end else if (primary_begin) begin
        switch_latched <= output_switch_bit;
    end
end

// ****************************************
// waveform output
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        waveform_out_pin <= 1'b0;
    end else if (switch_latched) begin
        // RULE_15 port latch value
        waveform_out_pin <= port_latch_bit;
    end else begin
        // RULE_13 level per phase
        // RULE_14 toggling waveform
        waveform_out_pin <= output_level_select_bit ^ secondary_phase;
    end
end

// ****************************************
// interrupts
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        sec_end_seen <= 1'b0;
        underflow_seen <= 1'b0;
    end else begin
        sec_end_seen <= main_under & secondary_phase;
        underflow_seen <= main_under;
    end
end

assign irq_clear = (wr_pending && wr_index == reg_index(`OFS_IRQ_CLEAR)) ?
    hwdata[IRQ_BITS-1:0] : {IRQ_BITS{1'b0}};
// RULE_07 raised with the output change
assign irq_event[`IRQ_SEC_END] = sec_end_seen;
assign irq_event[`IRQ_UNDERFLOW] = underflow_seen;

genvar gi;
generate
    for (gi = 0; gi < IRQ_BITS; gi = gi + 1) begin : g_irq
        // set wins over clear
        assign next_irq_status[gi] = irq_event[gi] | (irq_status[gi] & ~irq_clear[gi]);
    end
endgenerate

always @(posedge mclk) begin
    if (reset) begin
        irq_status <= `RST_IRQ;
    end else begin
        irq_status <= next_irq_status;
    end
end

// level request from enabled sticky bits
always @(posedge mclk) begin
    if (reset) begin
        irq <= 1'b0;
    end else begin
        irq <= |(next_irq_status & irq_enable);
    end
end

// ****************************************
// register writes
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        wr_pending <= 1'b0;
        wr_index <= 4'h0;
    end else begin
        wr_pending <= addr_phase & hwrite;
        wr_index <= rd_index;
    end
end

always @(posedge mclk) begin
    if (reset) begin
        prescaler_reload <= `RST_PERIOD;
        secondary_period_reg <= `RST_PERIOD;
        primary_commit <= `RST_PERIOD;
        secondary_commit <= `RST_PERIOD;
        timer_mode_reg <= `RST_MODE;
        output_control_reg <= `RST_OUTCTL;
        irq_enable <= `RST_IRQ;
    end else if (wr_pending) begin
        case (wr_index)
            // RULE_10 reload values only
            reg_index(`OFS_PRESCALER): begin
                prescaler_reload <= hwdata[WIDTH-1:0];
            end
            reg_index(`OFS_SECONDARY): begin
                secondary_period_reg <= hwdata[WIDTH-1:0];
            end
            // RULE_11 primary write commits both
            reg_index(`OFS_PRIMARY): begin
                primary_commit <= hwdata[WIDTH-1:0];
                secondary_commit <= secondary_period_reg;
            end
            reg_index(`OFS_MODE): begin
                timer_mode_reg <= hwdata[2:0];
            end
            reg_index(`OFS_OUTCTL): begin
                output_control_reg <= hwdata[2:0];
            end
            reg_index(`OFS_IRQ_ENABLE): begin
                irq_enable <= hwdata[IRQ_BITS-1:0];
            end
            default: begin
                irq_enable <= irq_enable;
            end
        endcase
    end
end

// ****************************************
// register reads
// ****************************************
always @* begin
    next_hrdata = 32'h0;
    case (rd_index)
        // RULE_08 live prescaler count
        reg_index(`OFS_PRESCALER): next_hrdata[WIDTH-1:0] = prescaler_count_reg;
        reg_index(`OFS_SECONDARY): next_hrdata[WIDTH-1:0] = secondary_period_reg;
        // RULE_09 main count in either phase
        reg_index(`OFS_PRIMARY): next_hrdata[WIDTH-1:0] = main_count;
        reg_index(`OFS_MODE): next_hrdata[2:0] = timer_mode_reg;
        reg_index(`OFS_OUTCTL): next_hrdata[2:0] = output_control_reg;
        reg_index(`OFS_IRQ_STATUS): next_hrdata[IRQ_BITS-1:0] = irq_status;
        reg_index(`OFS_IRQ_ENABLE): next_hrdata[IRQ_BITS-1:0] = irq_enable;
        default: next_hrdata = 32'h0;
    endcase
end

always @(posedge mclk) begin
    if (reset) begin
        hrdata <= 32'h0;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (addr_phase & ~hwrite) begin
            hrdata <= next_hrdata;
        end
    end
end

endmodule // wave_timer

// File: wave_timer_assertions.sv
`timescale 1ns/1ns
module wave_timer_assertions (
    // clock and reset
    input wire mclk,
    input wire reset,
    // bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // pins
    input wire waveform_out_pin,
    input wire irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire taken = hsel & htrans[1] & hready;
    wire rd = taken & !hwrite;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg run_q;
    reg en_q;
    reg [7:0] sec_q;
    reg [1:0] oc_cnt;
    // **********
    // shadow of written control state
    // **********
    always @(posedge mclk) begin
        if (reset) begin
            wr_pend <= 1'b0; wr_addr <= 8'h00; run_q <= 1'b0; en_q <= 1'b0; sec_q <= 8'hFF; oc_cnt <= 2'h0;
        end else begin
            wr_pend <= taken & hwrite;
            wr_addr <= haddr;
            oc_cnt <= (taken & hwrite & haddr == 8'h10) ? 2'h3 : (oc_cnt != 2'h0 ? oc_cnt - 2'h1 : 2'h0);
            if (wr_pend & wr_addr == 8'h0C) run_q <= hwdata[0];
            if (wr_pend & wr_addr == 8'h1C) en_q <= |hwdata[1:0];
            if (wr_pend & wr_addr == 8'h04) sec_q <= hwdata[7:0];
        end
    end
    ready_always_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    unmapped_zero_a: assert property (rd && haddr >= 8'h20 |=> hrdata == 32'h0) else $error("unmapped read");
    count_width_a: assert property (rd && haddr <= 8'h08 |=> hrdata[31:8] == 24'h0)
        else $error("count read wide");
    sec_readback_a: assert property (rd && haddr == 8'h04 |=> hrdata == {24'h0, $past(sec_q)})
        else $error("secondary read not stored value");
    mode_readback_a: assert property (rd && haddr == 8'h0C |=> hrdata[0] == $past(run_q))
        else $error("run bit read wrong");
    rdata_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
    stop_holds_pin_a: assert property ((!run_q && oc_cnt == 2'h0)[*3] |-> $stable(waveform_out_pin))
        else $error("pin moved while stopped");
    irq_masked_a: assert property ((!en_q)[*2] |-> !irq)
        else $error("irq while disabled");
    cover property ($rose(irq));
    cover property ($rose(waveform_out_pin));
    cover property (rd && haddr >= 8'h20);
endmodule // wave_timer_assertions

bind wave_timer wave_timer_assertions chk (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .waveform_out_pin(waveform_out_pin), .irq(irq));

// File: wave_monitor.sv
`timescale 1ns/1ns
module wave_monitor (
    // sampled pin
    input wire mclk,
    input wire pin,
    // last complete low and high run lengths in mclk cycles
    output reg [15:0] lo_len,
    output reg [15:0] hi_len
);
    reg [15:0] run = 16'h0000;
    reg last = 1'b0;
    initial lo_len = 16'h0000;
    initial hi_len = 16'h0000;
    always @(posedge mclk) begin
        if (pin === last) begin
            run <= run + 16'h0001;
        end else begin
            if (last) hi_len <= run; else lo_len <= run;
            run <= 16'h0001;
            last <= pin;
        end
    end
endmodule // wave_monitor

// File: alternating_period_waveform_timer_tb.sv
`timescale 1ns/1ns
module alternating_period_waveform_timer_tb;
    reg mclk = 0, reset = 1, hsel = 0, hwrite = 0, companion_underflow = 0, comp_en = 1, comp_kick = 0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0, ccnt = 2'h0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0, rd;
    reg [15:0] lfsr = 16'h0003;
    wire [31:0] hrdata;
    wire [15:0] lo_len, hi_len;
    wire hreadyout, hresp, waveform_out_pin, irq;
    wire hready = hreadyout;
    integer errors = 0, n_tests = 0, i, n, m, p, k, lv;
    wave_timer uut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .companion_underflow(companion_underflow), .waveform_out_pin(waveform_out_pin), .irq(irq));
    wave_monitor mon (.mclk(mclk), .pin(waveform_out_pin), .lo_len(lo_len), .hi_len(hi_len));
    initial forever #5 mclk = ~mclk;
    // companion pulse every fourth cycle, or one on demand
    always @(posedge mclk) begin
        ccnt <= ccnt + 2'h1;
        companion_underflow <= comp_kick | (comp_en & (ccnt == 2'h3));
    end
    function [15:0] next_rand(input [15:0] s);
        next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [31:0] plen(input integer kk, input integer nn, input integer xx);
        plen = kk * (nn + 1) * (xx + 1);
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
            @(posedge mclk);
            while (hready !== 1'b1) @(posedge mclk);
            htrans <= 2'h0; hwdata <= d;
            @(posedge mclk);
            while (hready !== 1'b1) @(posedge mclk);
            rd = hrdata;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            check(rd, e);
        end
    endtask
    task kick;
        begin
            @(posedge mclk);
            comp_kick <= 1'b1;
            @(posedge mclk);
            comp_kick <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    task conclude;
        begin
            $display("errors %0d tests %0d", errors, n_tests);
            if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        errors = errors + 1;
        conclude;
    end
    // **********
    // main sequence
    // **********
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rchk(8'h00, 32'hFF);
        rchk(8'h08, 32'hFF);
        rchk(8'h0C, 32'h0);
        rchk(8'h14, 32'h0);
        rchk(8'h24, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            lfsr = next_rand(lfsr);
            n = lfsr[1:0]; m = lfsr[4:2]; p = lfsr[7:5]; lv = i & 1;
            k = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 8 : 4;
            bus(1'b1, 8'h00, n); bus(1'b1, 8'h04, p);
            rchk(8'h04, p);
            if (i == 0) rchk(8'h00, 32'hFF);
            bus(1'b1, 8'h08, m); bus(1'b1, 8'h10, lv); bus(1'b1, 8'h1C, 32'h1);
            bus(1'b1, 8'h0C, (i << 1) | 1);
            repeat (3 * k * (n + 1) * (m + p + 2) + 20) @(posedge mclk);
            check({16'h0, lv ? hi_len : lo_len}, plen(k, n, m));
            check({16'h0, lv ? lo_len : hi_len}, plen(k, n, p));
            bus(1'b1, 8'h0C, 32'h0);
        end
        check(irq, 1'b1);
        rchk(8'h14, 32'h3);
        bus(1'b1, 8'h1C, 32'h0); repeat (2) @(posedge mclk);
        check(irq, 1'b0);
        bus(1'b1, 8'h1C, 32'h2); repeat (2) @(posedge mclk);
        check(irq, 1'b1);
        bus(1'b1, 8'h18, 32'h3);
        rchk(8'h14, 32'h0);
        rchk(8'h18, 32'h0);
        check(irq, 1'b0);
        bus(1'b1, 8'h10, 32'h0); bus(1'b1, 8'h00, 32'h0); bus(1'b1, 8'h04, 32'h2);
        bus(1'b1, 8'h08, 32'h1); bus(1'b1, 8'h0C, 32'h1);
        repeat (30) @(posedge mclk);
        check({16'h0, lo_len}, 32'h2);
        check({16'h0, hi_len}, 32'h3);
        bus(1'b1, 8'h04, 32'h5); repeat (30) @(posedge mclk);
        check({16'h0, hi_len}, 32'h3);
        bus(1'b1, 8'h08, 32'h1); repeat (30) @(posedge mclk);
        check({16'h0, hi_len}, 32'h6);
        bus(1'b1, 8'h10, 32'h1); repeat (30) @(posedge mclk);
        check({16'h0, hi_len}, 32'h2);
        check({16'h0, lo_len}, 32'h6);
        bus(1'b1, 8'h10, 32'h6); repeat (20) @(posedge mclk);
        repeat (4) begin
            repeat (3) @(posedge mclk);
            check(waveform_out_pin, 1'b1);
        end
        bus(1'b1, 8'h0C, 32'h0);
        // single-stepped companion source: live main count in both phases
        comp_en <= 1'b0;
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h3);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h0C, 32'h7);
        kick;
        rchk(8'h08, 32'h0);
        kick;
        rchk(8'h08, 32'h3);
        check(waveform_out_pin, 1'b1);
        kick;
        rchk(8'h08, 32'h2);
        rchk(8'h04, 32'h3);
        bus(1'b1, 8'h0C, 32'h0);
        conclude;
    end
endmodule // alternating_period_waveform_timer_tb
